// ### design/pio_pkg.sv
// constants, register map and carrier types of the parallel i/o port block
`default_nettype none

package pio_pkg;

  // ==========================================================================
  // geometry
  localparam int NPORT    = 6;
  localparam int PW       = 16;
  localparam int IN_W     = 14;
  localparam int NLINE    = NPORT * PW;
  // 65 bidirectional lines in six ports, plus 14 input-only lines
  localparam logic [NLINE-1:0] LINE_MASK = 96'h0003_00ff_00ff_ffff_7fff_ffff;
  // ports with an open-drain option and with a per-byte input threshold
  localparam logic [NPORT-1:0] OD_PORTS  = 6'h0e;
  localparam logic [NPORT-1:0] THR_PORTS = 6'h0f;

  // ==========================================================================
  // register map: paddr[7:5] selects the port, paddr[4:2] the register
  localparam logic [2:0] R_DOUT    = 3'h0;
  localparam logic [2:0] R_DIR     = 3'h1;
  localparam logic [2:0] R_ODRAIN  = 3'h2;
  localparam logic [2:0] R_PADCTL  = 3'h3;
  localparam logic [2:0] R_THRESH  = 3'h4;
  localparam logic [2:0] R_PIN_IN  = 3'h5;
  localparam logic [2:0] R_OUT_SET = 3'h6;
  localparam logic [2:0] R_OUT_CLR = 3'h7;
  localparam logic [2:0] IN_PORT_SEL = 3'h6;

  // pad control fields
  localparam int PAD_EDGE_LSB  = 0;
  localparam int PAD_DRIVE_LSB = 2;

  // ==========================================================================
  // per-port configuration
  typedef struct packed {
    logic [PW-1:0] dout;
    logic [PW-1:0] dir;
    logic [PW-1:0] odrain;
    logic [3:0]    pad;
    logic [1:0]    thresh;
  } pio_cfg_s;

  localparam pio_cfg_s CFG_RST = '0;

endpackage : pio_pkg

`default_nettype wire

// ### design/pio_top.sv
// parallel i/o port control with apb register access
//
// Summary of operation
// - 79 lines: six bidirectional ports, one input-only
// - set/clear registers change single lines only
// - one direction bit per bidirectional line
// - input lines have their driver switched off
// - per-pin open-drain select on some ports
// - reset forces all pins input except reset output
// - pad control selects edge shape and drive
// - per-byte ttl or hysteresis threshold select on ports 0 to 3
// - alternate functions override, else general purpose
//
// Local design decisions: register access over APB and the register addresses.
`default_nettype none

module pio_top
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // bidirectional pins
  input  wire logic [NLINE-1:0]  PIN_IN,
  output logic      [NLINE-1:0]  PIN_OUT,
  output logic      [NLINE-1:0]  PIN_OE,
  // input-only port
  input  wire logic [IN_W-1:0]   IN_PORT,
  // alternate peripheral functions
  input  wire logic [NLINE-1:0]  ALT_SEL,
  input  wire logic [NLINE-1:0]  ALT_OUT,
  input  wire logic [NLINE-1:0]  ALT_OE,
  // pad settings
  output logic [2*NPORT-1:0]     PAD_EDGE,
  output logic [2*NPORT-1:0]     PAD_DRIVE,
  output logic [2*NPORT-1:0]     IN_THRESH_SEL,
  // reset output, low while in reset
  output logic                   RESET_OUTPUT_PIN_N
);

  // ==========================================================================
  // state
  // one group of configuration flops per bidirectional port
  pio_cfg_s                  cfg_q [NPORT];
  pio_cfg_s                  cfg_d [NPORT];
  logic                      pready_q;
  logic                      pready_d;
  logic                      pslverr_q;
  logic                      pslverr_d;
  logic [31:0]               prdata_q;
  logic [31:0]               prdata_d;
  logic [NPORT-1:0][PW-1:0]  pin_o_q;
  logic [NPORT-1:0][PW-1:0]  pin_o_d;
  logic [NPORT-1:0][PW-1:0]  pin_oe_q;
  logic [NPORT-1:0][PW-1:0]  pin_oe_d;
  logic                      rst_out_n_q;
  logic                      rst_out_n_d;

  // ==========================================================================
  // apb decode
  logic [2:0]  sel_port;
  logic [2:0]  sel_reg;
  logic        hi_ok;
  logic        access;
  logic        commit;
  logic        mapped;
  logic        ro_hit;
  logic [31:0] rd_val;

  assign sel_port = PADDR[7:5];
  assign sel_reg  = PADDR[4:2];
  assign hi_ok    = (PADDR[11:8] == 4'h0);
  assign access   = PSEL & PENABLE;
  // one wait state: the transfer completes on the second access cycle
  assign commit   = access & pready_q;
  // refused: upper address bits, port 6 bar one register, all of port 7, pin register writes

  always_comb begin
    mapped = 1'b0;
    ro_hit = 1'b0;
    rd_val = 32'h0000_0000;
    if (hi_ok) begin
      for (int p = 0; p < NPORT; p++) begin
        if (sel_port == 3'(p)) begin
          mapped = 1'b1;
          ro_hit = (sel_reg == R_PIN_IN);
          unique case (sel_reg)
            R_DOUT:    rd_val = {16'h0000, cfg_q[p].dout};
            R_DIR:     rd_val = {16'h0000, cfg_q[p].dir};
            R_ODRAIN:  rd_val = {16'h0000, cfg_q[p].odrain};
            R_PADCTL:  rd_val = {28'h000_0000, cfg_q[p].pad};
            R_THRESH:  rd_val = {30'h0000_0000, cfg_q[p].thresh};
            R_PIN_IN:  rd_val = {16'h0000, PIN_IN[p*PW +: PW] & LINE_MASK[p*PW +: PW]};
            R_OUT_SET: rd_val = 32'h0000_0000;
            R_OUT_CLR: rd_val = 32'h0000_0000;
          endcase
        end
      end
      // input-only port has a single read-only data register
      if (sel_port == IN_PORT_SEL && sel_reg == R_PIN_IN) begin
        mapped = 1'b1;
        ro_hit = 1'b1;
        rd_val = {{(32-IN_W){1'b0}}, IN_PORT};
      end
    end
  end

  // ==========================================================================
  // register file and bus answer
  always_comb begin
    logic [PW-1:0] m;
    m = '0;
    for (int p = 0; p < NPORT; p++) begin
      cfg_d[p] = cfg_q[p];
    end
    pready_d  = access & ~pready_q;
    pslverr_d = access & ~pready_q & (~mapped | (PWRITE & ro_hit));
    // read data stands only in the answer cycle, zero otherwise
    prdata_d  = (access & ~pready_q & ~PWRITE) ? rd_val : 32'h0000_0000;
    // a refused write misses every case or only keeps dout, and leaves the registers alone
    if (commit && PWRITE && hi_ok) begin
      for (int p = 0; p < NPORT; p++) begin
        m = LINE_MASK[p*PW +: PW];
        if (sel_port == 3'(p)) begin
          unique case (sel_reg)
            R_DOUT:    cfg_d[p].dout   = PWDATA[PW-1:0] & m;
            R_DIR:     cfg_d[p].dir    = PWDATA[PW-1:0] & m;
            R_ODRAIN:  cfg_d[p].odrain = OD_PORTS[p] ? (PWDATA[PW-1:0] & m) : '0;
            R_PADCTL:  cfg_d[p].pad    = PWDATA[3:0];
            R_THRESH:  cfg_d[p].thresh = THR_PORTS[p] ? PWDATA[1:0] : 2'h0;
            R_PIN_IN:  cfg_d[p].dout   = cfg_q[p].dout;
            // only the lines whose write bit is one change
            R_OUT_SET: cfg_d[p].dout   = cfg_q[p].dout | (PWDATA[PW-1:0] & m);
            R_OUT_CLR: cfg_d[p].dout   = cfg_q[p].dout & ~(PWDATA[PW-1:0] & m);
          endcase
        end
      end
    end
    if (RST) begin
      for (int p = 0; p < NPORT; p++) begin
        cfg_d[p] = CFG_RST;
      end
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    for (int p = 0; p < NPORT; p++) begin
      cfg_q[p] <= cfg_d[p];
    end
    pready_q  <= pready_d;
    pslverr_q <= pslverr_d;
    prdata_q  <= prdata_d;
  end

  // ==========================================================================
  // pin drive, one slice per port
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [PW-1:0] m;
    logic [PW-1:0] alt;
    logic [PW-1:0] src_val;
    logic [PW-1:0] src_en;
    logic [PW-1:0] od;
    logic [PW-1:0] pp_en;
    logic [PW-1:0] od_en;
    assign m   = LINE_MASK[p*PW +: PW];
    assign alt = ALT_SEL[p*PW +: PW] & m;
    // alternate function takes the line, otherwise the gpio bits steer it
    assign src_val = (alt & ALT_OUT[p*PW +: PW]) | (~alt & cfg_q[p].dout);
    assign src_en  = ((alt & ALT_OE[p*PW +: PW]) | (~alt & cfg_q[p].dir)) & m;
    assign od      = cfg_q[p].odrain;
    assign pp_en   = src_en & ~od;
    // open drain only ever drives low, so the level is enabled only on zero
    assign od_en   = src_en & od & ~src_val;
    assign pin_o_d[p]  = RST ? '0 : (src_val & ~od);
    assign pin_oe_d[p] = RST ? '0 : (pp_en | od_en);
  end

  always_ff @(posedge CORE_CLK) begin
    pin_o_q     <= pin_o_d;
    pin_oe_q    <= pin_oe_d;
  end

  // ==========================================================================
  // reset output
  // kept out of the pin forcing above so it still drives while in reset
  assign rst_out_n_d = ~RST;

  always_ff @(posedge CORE_CLK) begin
    rst_out_n_q <= rst_out_n_d;
  end

  // ==========================================================================
  // outputs
  // pad settings are plain wiring of configuration flops
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      PAD_EDGE[2*p +: 2]      = cfg_q[p].pad[PAD_EDGE_LSB +: 2];
      PAD_DRIVE[2*p +: 2]     = cfg_q[p].pad[PAD_DRIVE_LSB +: 2];
      IN_THRESH_SEL[2*p +: 2] = cfg_q[p].thresh;
    end
  end

  assign PRDATA             = prdata_q;
  assign PREADY             = pready_q;
  assign PSLVERR            = pslverr_q;
  assign PIN_OUT            = pin_o_q;
  assign PIN_OE             = pin_oe_q;
  assign RESET_OUTPUT_PIN_N = rst_out_n_q;

endmodule : pio_top

`default_nettype wire

// ### verification/pio_board.sv
// board model: pull-ups on every port line
`default_nettype none
module pio_board
  import pio_pkg::*;
(
  // pad side of the block
  input  wire logic [NLINE-1:0] pin_out,
  input  wire logic [NLINE-1:0] pin_oe,
  output logic      [NLINE-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines float high, open drain only ever pulls low
  assign pin_in = (pin_oe & pin_out) | ~pin_oe;
endmodule : pio_board
`default_nettype wire

// ### verification/pio_props.sv
// timing checker of the port block
`default_nettype none
module pio_props
  import pio_pkg::*;
(
  // clock, reset, bus
  input wire logic               CORE_CLK,
  input wire logic               RST,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  // pins
  input wire logic [NLINE-1:0]   PIN_OUT,
  input wire logic [NLINE-1:0]   PIN_OE,
  input wire logic [NLINE-1:0]   ALT_SEL,
  input wire logic [NLINE-1:0]   ALT_OUT,
  input wire logic [NLINE-1:0]   ALT_OE,
  input wire logic [2*NPORT-1:0] PAD_EDGE,
  input wire logic [2*NPORT-1:0] PAD_DRIVE,
  input wire logic [2*NPORT-1:0] IN_THRESH_SEL,
  input wire logic               RESET_OUTPUT_PIN_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_oe_reset: assert property (disable iff (1'b0) RST |=> PIN_OE == '0)
    else $error("pin driven in reset");
  chk_reset_output_pin_low: assert property (disable iff (1'b0) RST |=> !RESET_OUTPUT_PIN_N)
    else $error("reset pin not low");
  chk_reset_output_pin_high: assert property (!RST |=> RESET_OUTPUT_PIN_N)
    else $error("reset pin not high");
  chk_unimpl_off: assert property ((PIN_OE & ~LINE_MASK) == '0)
    else $error("missing line driven");
  chk_alt_follow: assert property (ALT_SEL[0] |=> PIN_OE[0] == $past(ALT_OE[0]) && PIN_OUT[0] == $past(ALT_OUT[0]))
    else $error("alt line not followed");
  chk_ready_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("bus wait state wrong");
  chk_pad_reset: assert property (disable iff (1'b0) RST |=> {PAD_EDGE, PAD_DRIVE} == '0)
    else $error("pad setting in reset");
  chk_thr_reset: assert property (disable iff (1'b0) RST |=> IN_THRESH_SEL == '0)
    else $error("threshold in reset");
  cover property (PREADY && PSLVERR);
  cover property (PREADY && !PSLVERR);
  cover property (ALT_SEL[0] && ALT_OE[0]);
endmodule : pio_props
bind pio_top pio_props chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PREADY, .PSLVERR, .PIN_OUT, .PIN_OE, .ALT_SEL,
  .ALT_OUT, .ALT_OE, .PAD_EDGE, .PAD_DRIVE, .IN_THRESH_SEL, .RESET_OUTPUT_PIN_N);
`default_nettype wire

// ### verification/pio_top_bench.sv
// self-checking bench of the port block
`default_nettype none
module pio_top_bench;
  import pio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, rstn;
  logic [11:0] paddr = '0, edg, drv, thr;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [NLINE-1:0] pin_in, pin_out, pin_oe, asel = '0, aout = '0, aoe = '0;
  logic [13:0] in_port = 14'h2a5c;
  int mismatches = 0, checks_done = 0;
  always #10 clk = ~clk;
  pio_top uut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .IN_PORT(in_port), .ALT_SEL(asel), .ALT_OUT(aout), .ALT_OE(aoe), .PAD_EDGE(edg),
    .PAD_DRIVE(drv), .IN_THRESH_SEL(thr), .RESET_OUTPUT_PIN_N(rstn));
  pio_board brd (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  task chk(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask : chk
  // one transfer; a spare edge after release keeps back-to-back calls race free
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // no wait limit here: the watchdog ends a transfer that never completes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    chk(pslverr, err);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask : apb
  task t_gpio;
    apb(1, 12'h004, 32'h00ff, 0);
    apb(1, 12'h000, 32'h00a5, 0);
    apb(1, 12'h018, 32'h0002, 0);
    apb(1, 12'h01c, 32'h0001, 0);
    repeat (2) @(posedge clk);
    chk(pin_oe[15:0], 16'h00ff);
    chk(pin_out[7:0], 8'ha6);
    apb(0, 12'h014, 32'h0, 0);
    chk(rd, 32'hffa6);
  endtask : t_gpio
  task t_od;
    apb(1, 12'h024, 32'h0003, 0);
    apb(1, 12'h020, 32'h0001, 0);
    apb(1, 12'h028, 32'h0003, 0);
    repeat (2) @(posedge clk);
    chk({pin_oe[17:16], pin_out[17:16]}, 4'h8);
  endtask : t_od
  task t_pad;
    apb(1, 12'h04c, 32'h000d, 0);
    apb(1, 12'h070, 32'h0002, 0);
    apb(1, 12'h090, 32'h0003, 0);
    apb(0, 12'h090, 32'h0, 0);
    chk(rd, 32'h0);
    chk({edg[5:4], drv[5:4], thr[7:6]}, 6'h1e);
  endtask : t_pad
  task t_err;
    apb(1, 12'h100, 32'h1, 1);
    apb(1, 12'h014, 32'h1, 1);
    apb(1, 12'h0e0, 32'h1, 1);
    apb(0, 12'h0d4, 32'h0, 0);
    chk(rd, {18'h0, in_port});
    apb(0, 12'h000, 32'h0, 0);
    chk(rd, 32'h00a6);
    chk($countones(LINE_MASK) + IN_W, 8'h4f);
  endtask : t_err
  task t_alt;
    asel[0] <= 1;
    aout[0] <= 1;
    aoe[0] <= 1;
    repeat (2) @(posedge clk);
    chk({pin_oe[0], pin_out[0]}, 2'b11);
    asel[0] <= 0;
    repeat (2) @(posedge clk);
    chk({pin_oe[0], pin_out[0]}, 2'b10);
  endtask : t_alt
  task t_rst;
    rst <= 1;
    repeat (2) @(posedge clk);
    chk(pin_oe, 96'h0);
    chk(rstn, 1'b0);
    rst <= 0;
    repeat (2) @(posedge clk);
    chk(rstn, 1'b1);
    chk(pin_oe, 96'h0);
    chk({edg, drv, thr}, 36'h0);
  endtask : t_rst
  task finish_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_gpio;
    t_od;
    t_pad;
    t_err;
    t_alt;
    t_rst;
    finish_test;
  end
  // whole run takes about 1.7 us
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
endmodule : pio_top_bench
`default_nettype wire
